// file: verilog/pcgp_pkg.sv
// Package: register map, field layouts and reset values of the pad/GPIO port
`default_nettype none
package pcgp_pkg;
    localparam int NPIN = 12;
    localparam int NWAKE = 11;
    localparam int IRQ_EXC_NUM = 31;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFS_DATA   = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_MDATA  = 8'h08;
    localparam logic [7:0] OFS_SET    = 8'h0C;
    localparam logic [7:0] OFS_CLR    = 8'h10;
    localparam logic [7:0] OFS_TGL    = 8'h14;
    localparam logic [7:0] OFS_DIR    = 8'h18;
    localparam logic [7:0] OFS_DIRSET = 8'h1C;
    localparam logic [7:0] OFS_DIRCLR = 8'h20;
    localparam logic [7:0] OFS_DIRTGL = 8'h24;
    localparam logic [7:0] OFS_ISTAT  = 8'h28;
    localparam logic [7:0] OFS_IMASK  = 8'h2C;
    localparam logic [7:0] OFS_PADCFG = 8'h40;

    // Pad config word fields
    localparam int F_PIN_FUNCTION_SELECT_LSB  = 0;
    localparam int F_PULL_LSB  = 3;
    localparam int F_HYST      = 5;
    localparam int F_INV       = 6;
    localparam int F_LPF       = 7;
    localparam int F_I2CFLT    = 8;
    localparam int F_SINK      = 9;
    localparam int F_ILO_LSB   = 10;
    localparam int F_IHI_LSB   = 14;
    localparam int F_ANA_LSB   = 18;
    localparam int CFG_W       = 21;

    localparam logic [2:0] PIN_FUNCTION_SELECT_GPIO = 3'h0;

    typedef enum logic [1:0] {
        PCGP_PULL_NONE = 2'h0,
        PCGP_PULL_DOWN = 2'h1,
        PCGP_PULL_UP   = 2'h2,
        PCGP_PULL_REP  = 2'h3
    } pcgp_pull_type;

    localparam logic [31:0] CFG_RST      = 32'h0000_0000;
    // Serial bus pins reset to bus function with filter; debug pins to pin_function_select 1
    localparam logic [31:0] CFG_RST_I2C  = 32'h0000_0101;
    localparam logic [31:0] CFG_RST_DBG  = 32'h0000_0001;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              pu;
        logic              pd;
        logic              hyst;
        logic              lpf;
        logic              i2c_filter;
        logic              sink_mode;
        logic [3:0]        sink_level;
        logic [2:0]        ana_sel;
    } pcgp_pad_ctl_type;
endpackage : pcgp_pkg
`default_nettype wire

// file: verilog/pcgp_pad_cell.sv
// One pin's pad control: function routing, direction, pulls, sink and analog
`default_nettype none
module pcgp_pad_cell
    import pcgp_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [31:0]          cfg,
    input  wire logic                 gpio_dir,
    input  wire logic                 gpio_out,
    input  wire logic                 per_out,
    input  wire logic                 per_oe,
    input  wire logic                 pad_in,
    output logic                      pad_out,
    output logic                      pad_oe,
    output logic                      in_level,
    output pcgp_pad_ctl_type          ctl
);
    logic       is_gpio;
    logic       raw;
    logic [1:0] flt_q;
    logic       lvl_q;
    pcgp_pull_type pull;

    assign is_gpio  = cfg[F_PIN_FUNCTION_SELECT_LSB +: 3] == PIN_FUNCTION_SELECT_GPIO;
    assign pull     = pcgp_pull_type'(cfg[F_PULL_LSB +: 2]);
    assign raw      = pad_in ^ cfg[F_INV];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else if (is_gpio) begin
            pad_out <= gpio_out;
            pad_oe  <= gpio_dir;
        end else begin
            pad_out <= per_out;
            pad_oe  <= per_oe;
        end
    end

    // Low-pass: level accepted only after two equal samples
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flt_q <= 2'b00;
            lvl_q <= 1'b0;
        end else begin
            flt_q <= {flt_q[0], raw};
            if (!cfg[F_LPF] || (flt_q[1] == flt_q[0])) begin
                lvl_q <= cfg[F_LPF] ? flt_q[1] : raw;
            end
        end
    end
    assign in_level = lvl_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl <= '0;
        end else begin
            case (pull)
                PCGP_PULL_UP:   {ctl.pu, ctl.pd} <= 2'b10;
                PCGP_PULL_DOWN: {ctl.pu, ctl.pd} <= 2'b01;
                // Keeper follows the sensed level; retention in deep
                // power-down is not guaranteed since this logic is off
                PCGP_PULL_REP:  {ctl.pu, ctl.pd} <= {lvl_q, !lvl_q};
                default:        {ctl.pu, ctl.pd} <= 2'b00;
            endcase
            ctl.hyst       <= cfg[F_HYST];
            ctl.lpf        <= cfg[F_LPF];
            ctl.i2c_filter <= cfg[F_I2CFLT];
            ctl.sink_mode  <= cfg[F_SINK];
            ctl.sink_level <= gpio_out ? cfg[F_IHI_LSB +: 4]
                                       : cfg[F_ILO_LSB +: 4];
            ctl.ana_sel    <= is_gpio ? 3'h0 : cfg[F_ANA_LSB +: 3];
        end
    end
endmodule : pcgp_pad_cell
`default_nettype wire

// file: verilog/pcgp_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight
`default_nettype none
module pcgp_axil_slave (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic             wr_stb,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    input  wire logic        wr_err,
    output logic             rd_stb,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    logic aw_have_q;
    logic w_have_q;

    assign wr_stb = aw_have_q && w_have_q && !s_bvalid;
    assign rd_stb = s_arvalid && s_arready;
    assign rd_addr = s_araddr;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'h0;
            wr_addr   <= 8'h00;
            wr_data   <= 32'h0000_0000;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                s_awready <= 1'b0;
                wr_addr   <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                s_wready <= 1'b0;
                wr_data  <= s_wdata;
            end
            if (wr_stb) begin
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_err ? 2'h2 : 2'h0;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= 2'h0;
        end else if (rd_stb) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_err ? 32'h0000_0000 : rd_data;
            s_rresp   <= rd_err ? 2'h2 : 2'h0;
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end
endmodule : pcgp_axil_slave
`default_nettype wire

// file: verilog/pcgp_top.sv
// Top: pad configuration and fast GPIO port with interrupt and wake lines
//
// Operation
// - Function code zero routes pin to GPIO, other codes to a peripheral
// - In GPIO function the direction bit picks input or driven output
// - In peripheral function the peripheral sets direction; direction bit ignored
// - Pull field selects pull-up, pull-down, none or repeater
// - Pull field resets to no pull resistor
// - Repeater enables pull-up on high level, pull-down on low
// - Repeater retention need not hold in deep power-down
// - Serial bus pins select filtered bus mode or plain open-drain
// - High-drive pads offer sink mode switching low and high currents
// - Pad config also sets input mode, hysteresis and low-pass filter
// - Function select decides analog bus connections of analog pins
// - Port reached with single-cycle access; whole port written at once
// - Masked, set and clear writes leave other bits alone
// - Reset gives GPIO inputs, no pulls, except bus and debug pins
// - Each direction bit can be set, cleared and toggled
// - Each port bit is fixed to one physical pin
// - Combined port interrupt line drives exception input 31
// - Wake lines 0 to 10 follow pins 0 to 10
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module pcgp_top
    import pcgp_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            s_awaddr,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire logic [31:0]           s_wdata,
    input  wire logic [3:0]            s_wstrb,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    output logic [1:0]                 s_bresp,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    input  wire logic [7:0]            s_araddr,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    output logic [31:0]                s_rdata,
    output logic [1:0]                 s_rresp,
    output logic                       s_rvalid,
    input  wire logic                  s_rready,
    input  wire logic [pcgp_pkg::NPIN-1:0] pad_in,
    output logic [pcgp_pkg::NPIN-1:0]  pad_out,
    output logic [pcgp_pkg::NPIN-1:0]  pad_oe,
    input  wire logic [pcgp_pkg::NPIN-1:0] per_out,
    input  wire logic [pcgp_pkg::NPIN-1:0] per_oe,
    output logic [pcgp_pkg::NPIN-1:0]  per_in,
    output pcgp_pkg::pcgp_pad_ctl_type pad_ctl [pcgp_pkg::NPIN],
    output logic                       port_irq,
    output logic [pcgp_pkg::NWAKE-1:0] wake
);
    import pcgp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic             wr_stb;
    logic [7:0]       wr_addr;
    logic [31:0]      wr_data;
    logic             wr_err;
    logic             rd_stb;
    logic [7:0]       rd_addr;
    logic [31:0]      rd_data;
    logic             rd_err;
    logic [NPIN-1:0]  out_q;
    logic [NPIN-1:0]  mask_q;
    logic [NPIN-1:0]  dir_q;
    logic [NPIN-1:0]  istat_q;
    logic [NPIN-1:0]  imask_q;
    logic [NPIN-1:0]  lvl;
    logic [NPIN-1:0]  lvl_q;
    logic [31:0]      cfg_q [NPIN];
    logic [NPIN-1:0]  wd;
    logic             cfg_sel;
    logic [3:0]       cfg_idx;

    assign wd      = wr_data[NPIN-1:0];
    assign cfg_sel = (wr_addr >= OFS_PADCFG)
                   && (wr_addr < OFS_PADCFG + 8'(4 * NPIN));
    assign cfg_idx = 4'((wr_addr - OFS_PADCFG) >> 2);

    pcgp_axil_slave u_bus (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_stb    (wr_stb),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_err    (wr_err),
        .rd_stb    (rd_stb),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_err    (rd_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode; byte strobes are ignored, each write is a full word
    always_comb begin
        wr_err = 1'b0;
        if (wr_addr[1:0] != 2'b00) begin
            wr_err = 1'b1;
        end else if (wr_addr == OFS_DATA || wr_addr == OFS_MASK
                  || wr_addr == OFS_MDATA || wr_addr == OFS_SET
                  || wr_addr == OFS_CLR || wr_addr == OFS_TGL
                  || wr_addr == OFS_DIR || wr_addr == OFS_DIRSET
                  || wr_addr == OFS_DIRCLR || wr_addr == OFS_DIRTGL
                  || wr_addr == OFS_ISTAT || wr_addr == OFS_IMASK
                  || cfg_sel) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_q  <= '0;
            mask_q <= '0;
        end else if (wr_stb) begin
            if (wr_addr == OFS_DATA) begin
                out_q <= wd;
            end else if (wr_addr == OFS_MASK) begin
                mask_q <= wd;
            end else if (wr_addr == OFS_MDATA) begin
                out_q <= (out_q & mask_q) | (wd & ~mask_q);
            end else if (wr_addr == OFS_SET) begin
                out_q <= out_q | wd;
            end else if (wr_addr == OFS_CLR) begin
                out_q <= out_q & ~wd;
            end else if (wr_addr == OFS_TGL) begin
                out_q <= out_q ^ wd;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dir_q <= '0;
        end else if (wr_stb) begin
            if (wr_addr == OFS_DIR) begin
                dir_q <= wd;
            end else if (wr_addr == OFS_DIRSET) begin
                dir_q <= dir_q | wd;
            end else if (wr_addr == OFS_DIRCLR) begin
                dir_q <= dir_q & ~wd;
            end else if (wr_addr == OFS_DIRTGL) begin
                dir_q <= dir_q ^ wd;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            imask_q <= '0;
        end else if (wr_stb && wr_addr == OFS_IMASK) begin
            imask_q <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One config word and one pad cell per pin; index is the pin itself
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    if (gi == 4 || gi == 5) begin
                        cfg_q[gi] <= CFG_RST_I2C;
                    end else if (gi == 10 || gi == 11) begin
                        cfg_q[gi] <= CFG_RST_DBG;
                    end else begin
                        cfg_q[gi] <= CFG_RST;
                    end
                end else if (wr_stb && cfg_sel && cfg_idx == 4'(gi)) begin
                    cfg_q[gi] <= {11'h000, wr_data[CFG_W-1:0]};
                end
            end

            pcgp_pad_cell u_pad (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .cfg      (cfg_q[gi]),
                .gpio_dir (dir_q[gi]),
                .gpio_out (out_q[gi]),
                .per_out  (per_out[gi]),
                .per_oe   (per_oe[gi]),
                .pad_in   (pad_in[gi]),
                .pad_out  (pad_out[gi]),
                .pad_oe   (pad_oe[gi]),
                .in_level (lvl[gi]),
                .ctl      (pad_ctl[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Sticky edge status; an edge in the clearing read's cycle survives
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lvl_q   <= '0;
            istat_q <= '0;
        end else begin
            lvl_q <= lvl;
            if (rd_stb && rd_addr == OFS_ISTAT) begin
                istat_q <= lvl ^ lvl_q;
            end else begin
                istat_q <= istat_q | (lvl ^ lvl_q);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_irq <= 1'b0;
            wake     <= '0;
            per_in   <= '0;
        end else begin
            port_irq <= |(istat_q & imask_q);
            wake     <= lvl[NWAKE-1:0];
            per_in   <= lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (rd_addr == OFS_DATA || rd_addr == OFS_MDATA) begin
            rd_data[NPIN-1:0] = lvl;
        end else if (rd_addr == OFS_MASK) begin
            rd_data[NPIN-1:0] = mask_q;
        end else if (rd_addr == OFS_DIR) begin
            rd_data[NPIN-1:0] = dir_q;
        end else if (rd_addr == OFS_ISTAT) begin
            rd_data[NPIN-1:0] = istat_q;
        end else if (rd_addr == OFS_IMASK) begin
            rd_data[NPIN-1:0] = imask_q;
        end else if (rd_addr >= OFS_PADCFG
                  && rd_addr < OFS_PADCFG + 8'(4 * NPIN)
                  && rd_addr[1:0] == 2'b00) begin
            rd_data = cfg_q[4'((rd_addr - OFS_PADCFG) >> 2)];
        end else if (rd_addr == OFS_SET || rd_addr == OFS_CLR
                  || rd_addr == OFS_TGL || rd_addr == OFS_DIRSET
                  || rd_addr == OFS_DIRCLR || rd_addr == OFS_DIRTGL) begin
            rd_data = 32'h0000_0000;
        end else begin
            rd_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_set_write;
        wr_stb && wr_addr == OFS_SET;
    endsequence

    a_set_keeps_bits: assert property (@(posedge sys_clk) disable iff (rst)
        s_set_write |=> ((out_q & ~$past(wd)) == ($past(out_q) & ~$past(wd))))
        else $error("set write disturbed other bits");

    a_clr_clears: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && wr_addr == OFS_CLR) |=> ((out_q & $past(wd)) == '0))
        else $error("clear write left bits set");

    a_dir_toggle: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_stb && wr_addr == OFS_DIRTGL) |=> dir_q == ($past(dir_q) ^ $past(wd)))
        else $error("direction toggle wrong");

    a_gpio_oe_dir: assert property (@(posedge sys_clk) disable iff (rst)
        (cfg_q[0][2:0] == PIN_FUNCTION_SELECT_GPIO) |=> pad_oe[0] == $past(dir_q[0]))
        else $error("gpio direction not applied");

    a_per_oe_own: assert property (@(posedge sys_clk) disable iff (rst)
        (cfg_q[1][2:0] != PIN_FUNCTION_SELECT_GPIO) |=> pad_oe[1] == $past(per_oe[1]))
        else $error("peripheral direction not applied");

    a_irq_follows: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 port_irq == $past(|(istat_q & imask_q)))
        else $error("port interrupt wrong");

    a_wake_follows: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 wake == $past(lvl[NWAKE-1:0]))
        else $error("wake line wrong");

    a_data_read_live: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_stb && rd_addr == OFS_DATA) |=> s_rdata[NPIN-1:0] == $past(lvl))
        else $error("data read not pin level");

    a_reset_dir_in: assert property (@(posedge sys_clk)
        $past(rst) |-> dir_q == '0 && cfg_q[0] == CFG_RST)
        else $error("reset defaults wrong");
endmodule : pcgp_top
`default_nettype wire

// file: test/pcgp_pin_model.sv
// Pin-side model: external drivers, pulls and floating pins
`default_nettype none
module pcgp_pin_model
    import pcgp_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic [NPIN-1:0]  pad_out,
    input  wire logic [NPIN-1:0]  pad_oe,
    input  wire logic [NPIN-1:0]  ext_val,
    input  wire logic [NPIN-1:0]  ext_en,
    input  wire pcgp_pad_ctl_type pad_ctl [NPIN],
    output logic [NPIN-1:0]       pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NPIN-1:0] last_q;
    // An unpulled floating pin flips every cycle, so only a pull holds it
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_ctl[i].pu) pad_in[i] = 1'b1;
            else if (pad_ctl[i].pd) pad_in[i] = 1'b0;
            else pad_in[i] = ~last_q[i];
        end
    end
    always_ff @(posedge sys_clk) last_q <= pad_in;
endmodule : pcgp_pin_model
`default_nettype wire

// file: test/test_pcgp_top.sv
// Bench for the pad configuration and GPIO port
`default_nettype none
module test_pcgp_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pcgp_pkg::*;
    logic sys_clk = 0, rst = 1, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0;
    logic [7:0] s_awaddr = 0, s_araddr = 0;
    logic [31:0] s_wdata = 0, s_rdata, d;
    logic [NPIN-1:0] per_out = 0, per_oe = 0, ext_val = 0, ext_en = '1;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, port_irq;
    logic [1:0] s_bresp, s_rresp, r;
    logic [NPIN-1:0] pad_in, pad_out, pad_oe, per_in;
    logic [NWAKE-1:0] wake;
    pcgp_pad_ctl_type pad_ctl [NPIN];
    int err_total = 0, comparisons = 0, cyc = 0;
    pcgp_top dut(.sys_clk, .rst, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready(1'b1), .s_araddr, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready(1'b1), .pad_in, .pad_out,
        .pad_oe, .per_out, .per_oe, .per_in, .pad_ctl, .port_irq, .wake);
    pcgp_pin_model pm(.sys_clk, .pad_out, .pad_oe, .ext_val, .ext_en,
        .pad_ctl, .pad_in);
    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Ready lines stay high, so only the valids are handed back and forth
    // Handshakes are judged mid-cycle, where they equal the next edge's view
    task automatic wr(logic [7:0] a, logic [31:0] v);
        logic aw_ok, w_ok, done;
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1;
        s_wvalid <= 1;
        do begin
            @(negedge sys_clk);
            aw_ok = s_awvalid && s_awready;
            w_ok = s_wvalid && s_wready;
            done = s_bvalid;
            r = s_bresp;
            @(posedge sys_clk);
            if (aw_ok) s_awvalid <= 0;
            if (w_ok) s_wvalid <= 0;
        end while (!done);
    endtask : wr
    task automatic rd(logic [7:0] a);
        logic ar_ok, done;
        s_araddr <= a;
        s_arvalid <= 1;
        do begin
            @(negedge sys_clk);
            ar_ok = s_arvalid && s_arready;
            done = s_rvalid;
            d = s_rdata;
            r = s_rresp;
            @(posedge sys_clk);
            if (ar_ok) s_arvalid <= 0;
        end while (!done);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(OFS_PADCFG);
        chk("cfg0", CFG_RST, d);
        rd(OFS_PADCFG + 8'h10);
        chk("cfg4", CFG_RST_I2C, d);
        chk("oe", 0, 32'(pad_oe));
        rd(8'h3C);
        chk("resp", 32'(RESP_SLVERR), 32'(r));
        wr(8'h3C, 32'h0);
        chk("wresp", 32'(RESP_SLVERR), 32'(r));
        $display("reset test done");
    endtask : t_reset
    task automatic t_gpio;
        logic [7:0] hp [4] = '{8'h10, 8'h14, 8'h28, 8'h2C};
        foreach (hp[i]) wr(OFS_PADCFG + hp[i], 32'h0);
        wr(OFS_DIR, 32'h0000_0FFF);
        wr(OFS_DATA, 32'h0000_00F0);
        wr(OFS_SET, 32'h0000_0001);
        wr(OFS_CLR, 32'h0000_0010);
        wr(OFS_TGL, 32'h0000_0300);
        wr(OFS_MASK, 32'h0000_0F00);
        wr(OFS_MDATA, 32'h0000_0FFF);
        wr(OFS_MASK, 32'h0);
        repeat (3) @(posedge sys_clk);
        chk("out", 32'h3FF, 32'(pad_out));
        chk("oe", 32'hFFF, 32'(pad_oe));
        rd(OFS_DATA);
        chk("pins", 32'h3FF, d);
        wr(OFS_DIRCLR, 32'h0000_000F);
        wr(OFS_DIRTGL, 32'h0000_0003);
        wr(OFS_DIRSET, 32'h0000_0004);
        rd(OFS_DIR);
        chk("dir", 32'hFF7, d);
        wr(OFS_DIR, 32'h0);
        $display("gpio test done");
    endtask : t_gpio
    task automatic t_periph;
        wr(OFS_PADCFG, 32'h0000_0001);
        per_oe <= 12'h001;
        per_out <= 12'h001;
        repeat (3) @(posedge sys_clk);
        chk("poe", 1, 32'(pad_oe[0]));
        chk("pout", 1, 32'(pad_out[0]));
        per_oe <= 0;
        wr(OFS_DIR, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        chk("poe", 0, 32'(pad_oe[0]));
        wr(OFS_PADCFG, 32'h0);
        repeat (3) @(posedge sys_clk);
        chk("goe", 1, 32'(pad_oe[0]));
        wr(OFS_DIR, 32'h0);
        $display("peripheral test done");
    endtask : t_periph
    task automatic t_irq;
        wr(OFS_IMASK, 32'h0000_0002);
        rd(OFS_ISTAT);
        ext_val <= 12'h006;
        repeat (5) @(posedge sys_clk);
        chk("irq", 1, 32'(port_irq));
        chk("wake", 32'h6, 32'(wake));
        chk("perin", 32'h6, 32'(per_in));
        rd(OFS_ISTAT);
        chk("stat", 32'h6, d);
        repeat (3) @(posedge sys_clk);
        chk("irq", 0, 32'(port_irq));
        rd(OFS_DATA);
        chk("pins", 32'h6, d);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_rep;
        ext_val <= 12'h046;
        wr(OFS_PADCFG + 8'h18, 32'h0000_0018);
        ext_en <= 12'hFBF;
        repeat (5) @(posedge sys_clk);
        chk("pu", 1, 32'(pad_ctl[6].pu));
        chk("pd", 0, 32'(pad_ctl[6].pd));
        rd(OFS_DATA);
        chk("keep", 1, 32'(d[6]));
        wr(OFS_PADCFG + 8'h0C, 32'h0002_9620);
        repeat (3) @(posedge sys_clk);
        chk("sink", 1, 32'(pad_ctl[3].sink_mode));
        chk("ihi", 32'hA, 32'(pad_ctl[3].sink_level));
        chk("hyst", 1, 32'(pad_ctl[3].hyst));
        $display("repeater test done");
    endtask : t_rep
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        t_reset();
        t_gpio();
        t_periph();
        t_irq();
        t_rep();
        wrap_up();
    end
endmodule : test_pcgp_top
`default_nettype wire
